/* File: logic/fec_regs.vh */
// register map, field positions, reset values and timing of the fast event counter
`ifndef FEC_REGS_VH
`define FEC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define FEC_OFS_CTRL    12'h000
`define FEC_OFS_NEWDIR  12'h004
`define FEC_OFS_NEWCV   12'h008
`define FEC_OFS_NEWRV   12'h00c
`define FEC_OFS_NEWPER  12'h010
`define FEC_OFS_UPDATE  12'h014
`define FEC_OFS_COUNT   12'h018
`define FEC_OFS_PRESET  12'h01c
`define FEC_OFS_FREQ    12'h020
`define FEC_OFS_STATUS  12'h024
`define FEC_OFS_MASK    12'h028
`define FEC_OFS_INFO    12'h02c

// ****************************************
// fields
// ****************************************
`define FEC_CTRL_MODE_LSB 0
`define FEC_CTRL_RSTEN    3
`define FEC_CTRL_FREQEN   4
`define FEC_CTRL_ENABLE   5
`define FEC_UPD_DIR       0
`define FEC_UPD_CV        1
`define FEC_UPD_RV        2
`define FEC_UPD_PER       3
`define FEC_EV_EQ         0
`define FEC_EV_RST        1
`define FEC_EV_DIR        2
`define FEC_MODE_INTDIR   3'h0
`define FEC_MODE_EXTDIR   3'h1
`define FEC_MODE_TWOCLK   3'h2
`define FEC_MODE_QUAD     3'h3
`define FEC_MODE_PTOMON   3'h4
`define FEC_DIR_FWD       16'h0001
`define FEC_DIR_BWD       16'hffff
`define FEC_PER_10MS      2'h0
`define FEC_PER_100MS     2'h1
`define FEC_PER_1S        2'h2

// ****************************************
// reset values
// ****************************************
`define FEC_CTRL_RST      6'h00
`define FEC_PER_RST       2'h0

// ****************************************
// timing
// ****************************************
`define FEC_CLK_HZ        125000000
`define FEC_TICK_MS       1
`define FEC_MS_CYC        (`FEC_CLK_HZ / 1000 * `FEC_TICK_MS)
`define FEC_GATE0_MS      10
`define FEC_GATE1_MS      100
`define FEC_GATE2_MS      1000

`endif

/* File: logic/fec_sync.v */
// three-stage pin synchroniser with agreement filter and change pulse
`timescale 1ns/1ns
`default_nettype none

module fec_sync #(
  parameter W = 6
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // pins
  input  wire [W-1:0] pin_in,
  // clean levels and change pulses
  output reg  [W-1:0] lvl_r,
  output reg  [W-1:0] chg_r
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  wire [W-1:0] agree = ~(s2_r ^ s3_r);

  // first stage feeds only the second; a level counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= {W{1'b0}};
      s2_r  <= {W{1'b0}};
      s3_r  <= {W{1'b0}};
      lvl_r <= {W{1'b0}};
      chg_r <= {W{1'b0}};
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (agree & s3_r) | (~agree & lvl_r);
      chg_r <= agree & (s3_r ^ lvl_r);
    end
  end

endmodule // fec_sync

`default_nettype wire

/* File: logic/fec_counter.v */
// fast event counter top: pin decode, count, frequency gate, apb registers, interrupt
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "fec_regs.vh"

module fec_counter #(
  parameter MS_CYC = `FEC_MS_CYC   // cycles per millisecond tick
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // counter pins: clock/up/phase a, direction/down/phase b, reset/phase z
  input  wire        pin_a,
  input  wire        pin_b,
  input  wire        pin_z,
  // pulse train generator monitor
  input  wire        ptg_clk,
  input  wire        ptg_dir,
  input  wire        ptg_dir_en,
  // pins claimed by the current mode, the rest are free
  output reg         pin_a_used_r,
  output reg         pin_b_used_r,
  output reg         pin_z_used_r,
  // interrupt
  output reg         irq_r
);

  // ****************************************
  // synchronised pins
  // ****************************************
  wire [5:0] lvl;
  wire [5:0] chg;

  fec_sync #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({ptg_dir_en, ptg_dir, ptg_clk, pin_z, pin_b, pin_a}),
    .lvl_r   (lvl),
    .chg_r   (chg)
  );

  wire a_lvl  = lvl[0];
  wire b_lvl  = lvl[1];
  wire z_lvl  = lvl[2];
  wire a_rise = chg[0] & lvl[0];
  wire b_rise = chg[1] & lvl[1];
  wire z_rise = chg[2] & lvl[2];
  wire p_rise = chg[3] & lvl[3];

  // ****************************************
  // registers
  // ****************************************
  reg        [5:0]  ctrl_r;
  reg        [15:0] new_dir_r;
  reg        [31:0] count_load_value_r;
  reg        [31:0] preset_load_value_r;
  reg        [1:0]  new_per_r;
  reg               int_dir_r;
  reg signed [31:0] cnt_r;
  reg signed [31:0] cnt_nxt;
  reg        [31:0] preset_r;
  reg        [1:0]  per_r;
  reg        [31:0] freq_r;
  reg        [2:0]  status_r;
  reg        [2:0]  mask_r;
  reg               last_up_r;
  reg               moved_r;

  wire [2:0] mode    = ctrl_r[`FEC_CTRL_MODE_LSB +: 3];
  wire       rst_en  = ctrl_r[`FEC_CTRL_RSTEN] & (mode != `FEC_MODE_PTOMON);
  wire       freq_on = ctrl_r[`FEC_CTRL_FREQEN] & ~rst_en & (mode != `FEC_MODE_PTOMON);
  wire       enable  = ctrl_r[`FEC_CTRL_ENABLE];

  // apb strobes: a write takes effect in the access cycle, which always completes at once
  wire       wr_en  = psel & penable & pwrite & pready;
  wire       upd_wr = wr_en & (paddr == `FEC_OFS_UPDATE);
  wire       upd_dir = upd_wr & pwdata[`FEC_UPD_DIR];
  wire       upd_cv  = upd_wr & pwdata[`FEC_UPD_CV];
  wire       upd_rv  = upd_wr & pwdata[`FEC_UPD_RV];
  wire       upd_per = upd_wr & pwdata[`FEC_UPD_PER];

  // ****************************************
  // step decode
  // ****************************************
  reg step;
  reg up;

  // turn pin edges into one count step and its direction per mode
  always @* begin
    step = 1'b0;
    up   = 1'b1;
    case (mode)
      `FEC_MODE_INTDIR: begin
        step = a_rise;
        up   = int_dir_r;
      end
      `FEC_MODE_EXTDIR: begin
        step = a_rise;
        up   = b_lvl;
      end
      `FEC_MODE_TWOCLK: begin
        // coincident up and down edges cancel out
        step = a_rise ^ b_rise;
        up   = a_rise;
      end
      `FEC_MODE_QUAD: begin
        // x4 decode; a double change is a lost phase and is dropped
        step = chg[0] ^ chg[1];
        up   = chg[0] ? (a_lvl != b_lvl) : (a_lvl == b_lvl);
      end
      `FEC_MODE_PTOMON: begin
        step = p_rise;
        up   = lvl[5] ? lvl[4] : 1'b1;
      end
      default: begin
        step = 1'b0;
        up   = 1'b1;
      end
    endcase
    step = step & enable;
  end

  // reset input: pin z in every mode that allows it, phase z in quadrature
  wire rst_hold = rst_en & z_lvl;
  wire rst_ev   = rst_en & z_rise;

  // next count: reset holds zero, a software load wins over a step in the same cycle
  always @* begin
    cnt_nxt = cnt_r;
    if (rst_hold)
      cnt_nxt = 32'h0000_0000;
    else if (upd_cv)
      cnt_nxt = count_load_value_r;
    else if (step)
      cnt_nxt = up ? cnt_r + 32'sh0000_0001 : cnt_r - 32'sh0000_0001;
  end

  wire eq_ev  = (cnt_nxt == preset_r) & (cnt_r != preset_r);
  wire dir_ev = step & moved_r & (up != last_up_r) & ~rst_hold;

  // ****************************************
  // count and configuration state
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 32'sh0000_0000;
      preset_r  <= 32'h0000_0000;
      per_r     <= `FEC_PER_RST;
      int_dir_r <= 1'b1;
      last_up_r <= 1'b1;
      moved_r   <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      // flagged loads land in the same cycle; an unknown direction code or a period code above 1 s is not loaded
      if (upd_dir && new_dir_r == `FEC_DIR_FWD)
        int_dir_r <= 1'b1;
      else if (upd_dir && new_dir_r == `FEC_DIR_BWD)
        int_dir_r <= 1'b0;
      if (upd_rv)
        preset_r <= preset_load_value_r;
      if (upd_per && new_per_r <= `FEC_PER_1S)
        per_r <= new_per_r;
      if (step && !rst_hold) begin
        last_up_r <= up;
        moved_r   <= 1'b1;
      end
    end
  end

  // ****************************************
  // frequency gate
  // ****************************************
  reg [16:0] ms_div_r;
  reg [9:0]  ms_cnt_r;
  reg [31:0] pulse_r;

  // gate length in ticks of one millisecond
  function [9:0] gate_ms;
    input [1:0] sel;
    begin
      case (sel)
        `FEC_PER_10MS:  gate_ms = `FEC_GATE0_MS;
        `FEC_PER_100MS: gate_ms = `FEC_GATE1_MS;
        default:        gate_ms = `FEC_GATE2_MS;
      endcase
    end
  endfunction

  // pulses per gate times gates per second gives hertz
  function [31:0] to_hz;
    input [31:0] n;
    input [1:0]  sel;
    begin
      case (sel)
        `FEC_PER_10MS:  to_hz = n * 32'd100;
        `FEC_PER_100MS: to_hz = n * 32'd10;
        default:        to_hz = n;
      endcase
    end
  endfunction

  wire ms_tick  = ({15'h0000, ms_div_r} == MS_CYC - 1);
  wire gate_end = ms_tick & (ms_cnt_r == gate_ms(per_r) - 10'd1);

  // divider gives a one-cycle millisecond enable; a period change restarts the gate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_r <= 17'h0_0000;
      ms_cnt_r <= 10'h000;
      pulse_r  <= 32'h0000_0000;
      freq_r   <= 32'h0000_0000;
    end else begin
      ms_div_r <= ms_tick ? 17'h0_0000 : ms_div_r + 17'h0_0001;
      if (upd_per || !freq_on) begin
        ms_cnt_r <= 10'h000;
        pulse_r  <= 32'h0000_0000;
        if (!freq_on)
          freq_r <= 32'h0000_0000;
      end else if (gate_end) begin
        ms_cnt_r <= 10'h000;
        // the pulse that lands on the gate edge starts the next gate
        pulse_r  <= step ? 32'h0000_0001 : 32'h0000_0000;
        freq_r   <= to_hz(pulse_r, per_r);
      end else begin
        if (ms_tick)
          ms_cnt_r <= ms_cnt_r + 10'h001;
        if (step)
          pulse_r <= pulse_r + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  wire [2:0] ev_set = {dir_ev, rst_ev, eq_ev};
  wire [2:0] ev_clr = (wr_en && paddr == `FEC_OFS_STATUS) ? pwdata[2:0] : 3'h0;

  // set wins over a write-one-to-clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 3'h0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= (status_r & ~ev_clr) | ev_set;
      irq_r    <= |(((status_r & ~ev_clr) | ev_set) & mask_r);
    end
  end

  // ****************************************
  // pin ownership
  // ****************************************
  // free pins are reported so other functions may claim them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_used_r <= 1'b0;
      pin_b_used_r <= 1'b0;
      pin_z_used_r <= 1'b0;
    end else begin
      pin_a_used_r <= enable & (mode < `FEC_MODE_PTOMON);
      pin_b_used_r <= enable & (mode == `FEC_MODE_EXTDIR || mode == `FEC_MODE_TWOCLK ||
                                mode == `FEC_MODE_QUAD);
      pin_z_used_r <= enable & rst_en;
    end
  end

  // ****************************************
  // apb register file
  // ****************************************
  reg        map_hit;
  reg [31:0] rd_val;

  // read mux; count is read live while counting continues
  always @* begin
    map_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    case (paddr)
      `FEC_OFS_CTRL:   rd_val = {26'h000_0000, ctrl_r};
      `FEC_OFS_NEWDIR: rd_val = {16'h0000, new_dir_r};
      `FEC_OFS_NEWCV:  rd_val = count_load_value_r;
      `FEC_OFS_NEWRV:  rd_val = preset_load_value_r;
      `FEC_OFS_NEWPER: rd_val = {30'h0000_0000, new_per_r};
      `FEC_OFS_UPDATE: rd_val = {30'h0000_0000, per_r};
      `FEC_OFS_COUNT:  rd_val = cnt_r;
      `FEC_OFS_PRESET: rd_val = preset_r;
      `FEC_OFS_FREQ:   rd_val = freq_r;
      `FEC_OFS_STATUS: rd_val = {29'h0000_0000, status_r};
      `FEC_OFS_MASK:   rd_val = {29'h0000_0000, mask_r};
      `FEC_OFS_INFO:   rd_val = {29'h0000_0000, z_lvl, last_up_r, int_dir_r};
      default:         map_hit = 1'b0;
    endcase
  end

  // zero-wait slave: data and answer are registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      ctrl_r              <= `FEC_CTRL_RST;
      new_dir_r           <= `FEC_DIR_FWD;
      count_load_value_r  <= 32'h0000_0000;
      preset_load_value_r <= 32'h0000_0000;
      new_per_r           <= `FEC_PER_RST;
      mask_r              <= 3'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~map_hit | (pwrite & paddr[11:0] >= `FEC_OFS_COUNT &
                 paddr != `FEC_OFS_STATUS & paddr != `FEC_OFS_MASK));
      if (psel && !penable && !pwrite)
        prdata <= rd_val;
      if (wr_en) begin
        case (paddr)
          `FEC_OFS_CTRL:   ctrl_r              <= pwdata[5:0];
          `FEC_OFS_NEWDIR: new_dir_r           <= pwdata[15:0];
          `FEC_OFS_NEWCV:  count_load_value_r  <= pwdata;
          `FEC_OFS_NEWRV:  preset_load_value_r <= pwdata;
          `FEC_OFS_NEWPER: new_per_r           <= pwdata[1:0];
          `FEC_OFS_MASK:   mask_r              <= pwdata[2:0];
          default:         mask_r              <= mask_r;
        endcase
      end
    end
  end

endmodule // fec_counter

`default_nettype wire

/* File: bench/fec_counter_checker.sv */
// assertion checker on the fast event counter ports
`timescale 1ns/1ns
`default_nettype none
`include "fec_regs.vh"

module fec_counter_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin claims and interrupt
  input wire logic        pin_a_used_r,
  input wire logic        pin_b_used_r,
  input wire logic        pin_z_used_r,
  input wire logic        irq_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed control write with its mode and reset-input choice
  wire       ctl_w = pready && pwrite && paddr == `FEC_OFS_CTRL && pwdata[`FEC_CTRL_ENABLE];
  wire [2:0] md    = pwdata[2:0];
  wire       rs    = pwdata[3];
  wire [2:0] used  = {pin_a_used_r, pin_b_used_r, pin_z_used_r};

  // ****************
  // bus handshake
  // ****************
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ro_count_a: assert property (pready && pwrite && paddr == `FEC_OFS_COUNT |-> pslverr)
    else $error("count write accepted");
  unmapped_read_a: assert property (pready && !pwrite && paddr == 12'h030 |->
    pslverr && prdata == 32'h0) else $error("unmapped read not refused");

  // ****************
  // pin claims and interrupt
  // ****************
  intdir_pins_a: assert property (ctl_w && md == 3'h0 && !rs |-> ##2 used == 3'h4)
    else $error("internal direction pins wrong");
  extdir_pins_a: assert property (ctl_w && md == 3'h1 && !rs |-> ##2 used == 3'h6)
    else $error("external direction pins wrong");
  twoclk_pins_a: assert property (ctl_w && md == 3'h2 && !rs |-> ##2 used == 3'h6)
    else $error("two clock pins wrong");
  quad_reset_pins_a: assert property (ctl_w && md == 3'h3 && rs |-> ##2 used == 3'h7)
    else $error("quadrature pins wrong");
  mask_quiet_a: assert property (pready && pwrite && paddr == `FEC_OFS_MASK &&
    pwdata[2:0] == 3'h0 |-> ##2 !irq_r) else $error("masked interrupt still high");
endmodule // fec_counter_checker

bind fec_counter fec_counter_checker chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_a_used_r(pin_a_used_r), .pin_b_used_r(pin_b_used_r), .pin_z_used_r(pin_z_used_r),
  .irq_r(irq_r));
`default_nettype wire

/* File: bench/fec_encoder_model.sv */
// incremental encoder model driving the counter pins from its own link clock
`timescale 1ns/1ns
`default_nettype none

module fec_encoder_model (
  // encoder lines, always driven
  output var logic pin_a,
  output var logic pin_b,
  output var logic pin_z
);
  logic lclk  = 1'b0;
  logic run_r = 1'b0;

  // 64 ns link clock, phase offset from pclk so edges never line up
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    pin_z = 1'b0;
    #3;
    forever #32 lclk = ~lclk;
  end

  // free-running square wave for the frequency gate
  always @(posedge lclk) begin
    if (run_r) begin
      pin_a <= ~pin_a;
    end
  end

  // rising-edge pulses on the first line, or on the second when onb is set
  task automatic pulses(input int k, input logic onb);
    repeat (k) begin
      @(posedge lclk);
      pin_a <= pin_a | !onb;
      pin_b <= pin_b | onb;
      @(posedge lclk);
      pin_a <= pin_a & onb;
      pin_b <= pin_b & !onb;
    end
  endtask

  // one gray-code step per link edge, so a and b never move together
  task automatic quad(input int k, input logic fwd);
    repeat (k) begin
      @(posedge lclk);
      pin_a <= pin_a ^ (fwd == (pin_a == pin_b));
      pin_b <= pin_b ^ (fwd != (pin_a == pin_b));
    end
  endtask

  // direction level and index line
  task automatic lv(input logic b, input logic z);
    @(posedge lclk);
    pin_b <= b;
    pin_z <= z;
  endtask
endmodule // fec_encoder_model
`default_nettype wire

/* File: bench/test_high_speed_event_counter.sv */
// self-checking bench: integer model of count and events against the counter
`timescale 1ns/1ns
`default_nettype none
`include "fec_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module test_high_speed_event_counter;
  localparam int MS = 4; // short millisecond tick keeps the gates brief
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        ptg_clk = 1'b0;
  logic        ptg_dir = 1'b0;
  logic        ptg_den = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin_a, pin_b, pin_z, ua, ub, uz, irq;
  wire  [2:0]  used = {ua, ub, uz};
  logic [31:0] q;
  logic        err;
  int          mismatches = 0;
  int          checks     = 0;
  int          cyc        = 0;
  integer      seed       = 32'heea9;
  int          exp_cnt    = 0;
  int          exp_pre    = 0;
  int          exp_st     = 0;
  int          last_d     = 1;
  int          n, r, f, sc;

  fec_counter #(.MS_CYC(MS)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z),
    .ptg_clk(ptg_clk), .ptg_dir(ptg_dir), .ptg_dir_en(ptg_den), .pin_a_used_r(ua),
    .pin_b_used_r(ub), .pin_z_used_r(uz), .irq_r(irq));
  fec_encoder_model enc (.pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z));

  always #4 pclk = ~pclk;

  // cycle ceiling cuts a hung run short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; an idle edge follows so strobes never re-rise in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input int e,
                        input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e & m, q & m)
  endtask

  // enable in a mode, then compare the claimed pins with the mode's needs
  task automatic cfg(input logic [2:0] md, input logic rs, input logic fq);
    logic [2:0] pins;
    pins = {md < 3'h4, md == 3'h1 || md == 3'h2 || md == 3'h3, rs && md != 3'h4};
    apb(1'b1, `FEC_OFS_CTRL, {26'h0, 1'b1, fq, rs, md});
    @(posedge pclk);
    `CHK("pins", pins, used)
  endtask

  // model of k steps: count, equality and direction change events
  task automatic mstep(input int d, input int k);
    repeat (k) begin
      exp_cnt += d;
      if (d != last_d) exp_st |= 4;
      last_d = d;
      if (exp_cnt == exp_pre) exp_st |= 1;
    end
  endtask

  task automatic pul(input int k, input logic onb, input int d);
    enc.pulses(k, onb);
    mstep(d, k);
    repeat (8) @(posedge pclk);
  endtask

  task automatic qd(input int k, input logic fwd);
    enc.quad(k, fwd);
    mstep(fwd ? 1 : -1, k);
    repeat (8) @(posedge pclk);
  endtask

  task automatic chk_cs(input logic [31:0] m);
    rd_chk(`FEC_OFS_COUNT, 32'hffffffff, exp_cnt, "count");
    rd_chk(`FEC_OFS_STATUS, m, exp_st, "status");
  endtask

  // write-one-clear of every event, then let the interrupt settle
  task automatic clr();
    apb(1'b1, `FEC_OFS_STATUS, 32'h7);
    @(posedge pclk);
    exp_st = 0;
  endtask

  task automatic ptg_run(input int k);
    repeat (k) begin
      ptg_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ptg_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`FEC_OFS_CTRL, 32'hffffffff, 0, "ctrl");
    apb(1'b1, `FEC_OFS_COUNT, 32'h5);
    `CHK("ro write", 1'b1, err)
    apb(1'b0, 12'h030, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, `FEC_OFS_MASK, 32'h7);
    cfg(3'h0, 1'b0, 1'b0);
    n = 1 + ($random(seed) & 7);
    pul(n, 1'b0, 1);
    apb(1'b1, `FEC_OFS_NEWDIR, {16'h0, `FEC_DIR_BWD});
    apb(1'b1, `FEC_OFS_UPDATE, 32'h1);
    pul(n + 2, 1'b0, -1);
    chk_cs(32'h7);
    `CHK("irq", 1'b1, irq)
    clr();
    `CHK("irq clear", 1'b0, irq)
    enc.lv(1'b0, 1'b0);
    cfg(3'h1, 1'b0, 1'b0);
    pul(3, 1'b0, -1);
    enc.lv(1'b1, 1'b0);
    pul(2, 1'b0, 1);
    chk_cs(32'h7);
    enc.lv(1'b0, 1'b0);
    cfg(3'h2, 1'b0, 1'b0);
    pul(4, 1'b0, 1);
    pul(1, 1'b1, -1);
    chk_cs(32'h7);
    cfg(3'h3, 1'b0, 1'b0);
    qd(6, 1'b1);
    qd(3, 1'b0);
    chk_cs(32'h7);
    apb(1'b1, `FEC_OFS_NEWRV, 32'h64);
    apb(1'b1, `FEC_OFS_UPDATE, 32'h4);
    exp_pre = 100;
    cfg(3'h3, 1'b1, 1'b0);
    clr();
    enc.lv(pin_b, 1'b1);
    enc.quad(4, 1'b1);
    repeat (8) @(posedge pclk);
    rd_chk(`FEC_OFS_COUNT, 32'hffffffff, 0, "held");
    rd_chk(`FEC_OFS_STATUS, 32'h2, 2, "reset event");
    enc.lv(pin_b, 1'b0);
    exp_cnt = 0;
    qd(4, 1'b1);
    rd_chk(`FEC_OFS_COUNT, 32'hffffffff, exp_cnt, "resumed");
    cfg(3'h0, 1'b0, 1'b0);
    r = $random(seed) & 32'hffff;
    apb(1'b1, `FEC_OFS_NEWDIR, 32'h1);
    apb(1'b1, `FEC_OFS_NEWCV, r);
    apb(1'b1, `FEC_OFS_NEWRV, r + 3);
    apb(1'b1, `FEC_OFS_UPDATE, 32'h7);
    exp_cnt = r;
    exp_pre = r + 3;
    rd_chk(`FEC_OFS_PRESET, 32'hffffffff, exp_pre, "preset");
    apb(1'b1, `FEC_OFS_MASK, 32'h1);
    clr();
    pul(3, 1'b0, 1);
    chk_cs(32'h1);
    `CHK("irq eq", 1'b1, irq)
    apb(1'b1, `FEC_OFS_NEWRV, r + 5);
    apb(1'b1, `FEC_OFS_UPDATE, 32'h4);
    exp_pre = r + 5;
    clr();
    `CHK("irq handled", 1'b0, irq)
    pul(2, 1'b0, 1);
    chk_cs(32'h1);
    apb(1'b1, `FEC_OFS_MASK, 32'h0);
    @(posedge pclk);
    `CHK("irq masked", 1'b0, irq)
    enc.run_r = 1'b1;
    cfg(3'h0, 1'b0, 1'b1);
    for (int p = 0; p < 3; p++) begin
      sc = (p == 0) ? 100 : (p == 1) ? 10 : 1;
      apb(1'b1, `FEC_OFS_NEWPER, p);
      apb(1'b1, `FEC_OFS_UPDATE, 32'h8);
      repeat (2 * MS * 1000 / sc + 40) @(posedge pclk);
      apb(1'b0, `FEC_OFS_FREQ, 32'h0);
      f = q;
      `CHK("freq", 1'b1, (f % sc == 0) && f >= 250 - sc && f <= 250 + sc)
    end
    rd_chk(`FEC_OFS_UPDATE, 32'h3, 2, "period");
    apb(1'b1, `FEC_OFS_NEWPER, 32'h3);
    apb(1'b1, `FEC_OFS_UPDATE, 32'h8);
    rd_chk(`FEC_OFS_UPDATE, 32'h3, 2, "period kept");
    cfg(3'h0, 1'b1, 1'b1);
    repeat (100) @(posedge pclk);
    rd_chk(`FEC_OFS_FREQ, 32'hffffffff, 0, "freq off");
    enc.run_r = 1'b0;
    cfg(3'h4, 1'b0, 1'b0);
    apb(1'b1, `FEC_OFS_NEWCV, 32'h0);
    apb(1'b1, `FEC_OFS_UPDATE, 32'h2);
    ptg_run(5);
    ptg_den <= 1'b1;
    ptg_run(2);
    rd_chk(`FEC_OFS_COUNT, 32'hffffffff, 3, "monitor");
    give_verdict();
  end
endmodule // test_high_speed_event_counter
`default_nettype wire
